/* core/perf_event_select_decoder.sv */
/*
 * event-select decoder and counter for one performance counter.
 * software programs an event code and unit mask over a plain register
 * port; pipeline units present one-cycle event indications that are
 * synchronous to ref_clk.
 */
`timescale 1ns/1ps
module perf_event_select_decoder (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [perf_sel_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [perf_sel_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [perf_sel_pkg::DATA_W-1:0] reg_rdata,
	input wire logic rename_buf_stall,
	input wire logic mem_buf_stall,
	input wire logic other_resource_stall,
	input wire logic bus_queue_full_stall,
	input wire logic miss_limit_stall,
	input wire logic mispredict_recovery_stall,
	input wire logic store_drain_stall,
	input wire logic partial_alias_stall,
	input wire logic flag_partial_stall,
	input wire logic segment_load,
	input wire logic halted,
	input wire logic packed_int_exec,
	input wire logic packed_store_move,
	input wire logic saturating_exec,
	input wire logic packed_int_microop,
	input wire logic [perf_sel_pkg::N_CLASS-1:0] packed_int_class,
	input wire logic packed_to_float,
	input wire logic float_to_packed,
	input wire logic packed_state_empty_instruction,
	input wire logic packed_int_retired,
	input wire logic [perf_sel_pkg::N_SEG-1:0] segment_rename_stall,
	input wire logic [perf_sel_pkg::N_SEG-1:0] segment_rename,
	input wire logic retired_segment_rename,
	output logic count_active,
	output logic [perf_sel_pkg::DATA_W-1:0] count_value
);
	import perf_sel_pkg::*;

	// --------------------------------------------------------------
	// select and counter registers
	// --------------------------------------------------------------
	logic [7:0] code_r;
	logic [7:0] mask_r;
	logic en_r;
	logic [DATA_W-1:0] count_r;
	logic [DATA_W-1:0] count_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic active_r;
	logic [INC_W-1:0] inc_r;

	// --------------------------------------------------------------
	// register decode
	// --------------------------------------------------------------
	wire sel_wr = reg_wr && (reg_addr == OFS_SELECT);
	wire cnt_wr = reg_wr && (reg_addr == OFS_COUNT);
	wire sel_hit = reg_addr == OFS_SELECT;
	wire cnt_hit = reg_addr == OFS_COUNT;
	wire stat_hit = reg_addr == OFS_STATUS;

	// --------------------------------------------------------------
	// per-bit qualification by the unit mask
	// --------------------------------------------------------------
	logic [N_CLASS-1:0] class_hit;
	logic [N_SEG-1:0] ren_stall_hit;
	logic [N_SEG-1:0] ren_hit;
	genvar gi;
	generate
		for (gi = 0; gi < N_CLASS; gi++) begin : g_bit
			assign class_hit[gi] = packed_int_class[gi] & mask_r[gi];
			if (gi < N_SEG) begin : g_seg
				assign ren_stall_hit[gi] = segment_rename_stall[gi] & mask_r[gi];
				assign ren_hit[gi] = segment_rename[gi] & mask_r[gi];
			end
		end
	endgenerate

	function automatic logic [INC_W-1:0] ones(input logic [N_CLASS-1:0] v);
		logic [INC_W-1:0] n;
		n = INC_ZERO;
		for (int i = 0; i < N_CLASS; i++) begin
			n = n + {2'b00, v[i]};
		end
		return n;
	endfunction

	// --------------------------------------------------------------
	// event conditions
	// --------------------------------------------------------------
	// the bus-queue and miss-limit stall inputs are deliberately not ORed
	// in: those cycles only count when another listed stall is present
	wire resource_cycle = rename_buf_stall | mem_buf_stall | other_resource_stall
		| mispredict_recovery_stall | store_drain_stall;
	wire unused_excluded = bus_queue_full_stall | miss_limit_stall;
	wire partial_cycle = partial_alias_stall | flag_partial_stall;
	wire exec_counted = packed_int_exec & ~packed_store_move;

	wire mask_none = mask_r == UM_NONE;
	wire mask_one = mask_r == UM_ONE;
	wire mask_all4 = mask_r == UM_ALL4;
	wire seg_mask_ok = mask_all4 || (mask_r != UM_NONE && (mask_r & ~UM_ALL4) == UM_NONE
		&& (mask_r & (mask_r - UM_ONE)) == UM_NONE);
	wire class_mask_ok = mask_r != UM_NONE && (mask_r & ~UM_CLASS_FIELD) == UM_NONE;

	// --------------------------------------------------------------
	// per-event legality and increment
	// --------------------------------------------------------------
	// each event owns a pair of named terms, so the selector below stays
	// a plain pick and a new event touches one place only
	wire legal_resource = mask_none;
	wire [INC_W-1:0] inc_resource = {2'b00, resource_cycle};

	wire legal_partial = mask_none;
	wire [INC_W-1:0] inc_partial = {2'b00, partial_cycle};

	wire legal_seg_load = mask_none;
	wire [INC_W-1:0] inc_seg_load = {2'b00, segment_load};

	wire legal_unhalted = mask_none;
	wire [INC_W-1:0] inc_unhalted = {2'b00, ~halted};

	wire legal_exec = mask_none;
	wire [INC_W-1:0] inc_exec = {2'b00, exec_counted};

	wire legal_sat = mask_none;
	wire [INC_W-1:0] inc_sat = {2'b00, saturating_exec};

	wire legal_microop = mask_all4;
	wire [INC_W-1:0] inc_microop = {2'b00, packed_int_microop};

	wire legal_class = class_mask_ok;
	wire [INC_W-1:0] inc_class = ones(class_hit);

	// mask 01 picks the float-to-packed direction, mask 00 the other one
	wire legal_transition = mask_none | mask_one;
	wire transition_pick = mask_one ? float_to_packed : packed_to_float;
	wire [INC_W-1:0] inc_transition = {2'b00, transition_pick};

	wire legal_state_empty = mask_none;
	wire [INC_W-1:0] inc_state_empty = {2'b00, packed_state_empty_instruction};

	wire legal_retired = mask_none;
	wire [INC_W-1:0] inc_retired = {2'b00, packed_int_retired};

	wire legal_ren_stall = seg_mask_ok;
	wire [INC_W-1:0] inc_ren_stall = ones({2'b00, ren_stall_hit});

	wire legal_rename = seg_mask_ok;
	wire [INC_W-1:0] inc_rename = ones({2'b00, ren_hit});

	wire legal_ret_rename = mask_none;
	wire [INC_W-1:0] inc_ret_rename = {2'b00, retired_segment_rename};

	// --------------------------------------------------------------
	// event selection
	// --------------------------------------------------------------
	logic legal;
	logic [INC_W-1:0] inc;
	always_comb begin
		legal = 1'b0;
		inc = INC_ZERO;
		unique case (code_r)
			EV_RESOURCE_STALL: begin
				legal = legal_resource;
				inc = inc_resource;
			end

			EV_PARTIAL_STALL: begin
				legal = legal_partial;
				inc = inc_partial;
			end

			EV_SEG_LOAD: begin
				legal = legal_seg_load;
				inc = inc_seg_load;
			end

			EV_UNHALTED: begin
				legal = legal_unhalted;
				inc = inc_unhalted;
			end

			EV_PI_EXEC: begin
				legal = legal_exec;
				inc = inc_exec;
			end

			EV_PI_SAT: begin
				legal = legal_sat;
				inc = inc_sat;
			end

			EV_PI_UOP: begin
				legal = legal_microop;
				inc = inc_microop;
			end

			EV_PI_CLASS: begin
				legal = legal_class;
				inc = inc_class;
			end

			EV_TRANSITION: begin
				legal = legal_transition;
				inc = inc_transition;
			end

			EV_STATE_EMPTY: begin
				legal = legal_state_empty;
				inc = inc_state_empty;
			end

			EV_PI_RETIRED: begin
				legal = legal_retired;
				inc = inc_retired;
			end

			EV_SEG_REN_STALL: begin
				legal = legal_ren_stall;
				inc = inc_ren_stall;
			end

			EV_SEG_RENAME: begin
				legal = legal_rename;
				inc = inc_rename;
			end

			EV_RET_SEG_REN: begin
				legal = legal_ret_rename;
				inc = inc_ret_rename;
			end

			default: begin
				legal = 1'b0;
				inc = INC_ZERO;
			end
		endcase
	end

	// an illegal code or mask combination counts nothing, so a stale mask
	// left over from another event can never leak stray counts
	wire active = en_r & legal;
	wire [INC_W-1:0] inc_eff = active ? inc : INC_ZERO;

	// a software write to the counter wins over a count in the same cycle
	assign count_nxt = cnt_wr ? reg_wdata : count_r + {{(DATA_W-INC_W){1'b0}}, inc_eff};

	wire [DATA_W-1:0] sel_word = {{(DATA_W-SEL_EN_BIT-1){1'b0}}, en_r, mask_r, code_r};
	wire [DATA_W-1:0] stat_word = {{(DATA_W-STAT_INC_LSB-INC_W){1'b0}}, inc_r,
		2'b00, active_r, legal};
	// reads are strobe-qualified so the port rests at zero between reads
	wire rd_sel = reg_rd && sel_hit;
	wire rd_cnt = reg_rd && cnt_hit;
	wire rd_stat = reg_rd && stat_hit;
	assign rdata_nxt = rd_sel ? sel_word :
		rd_cnt ? count_r :
		rd_stat ? stat_word : ZERO_WORD;

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			code_r <= CODE_RST;
			mask_r <= MASK_RST;
			en_r <= 1'b0;
		end else if (sel_wr) begin
			code_r <= reg_wdata[SEL_CODE_LSB +: 8];
			mask_r <= reg_wdata[SEL_MASK_LSB +: 8];
			en_r <= reg_wdata[SEL_EN_BIT];
		end
	end

	// the counter wraps silently at the top of its range
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_r <= COUNT_RST;
		end else begin
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdata_r <= ZERO_WORD;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			active_r <= 1'b0;
		end else begin
			active_r <= active;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			inc_r <= INC_ZERO;
		end else begin
			inc_r <= inc_eff;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign reg_rdata = rdata_r;
	assign count_active = active_r;
	assign count_value = count_r;
endmodule

/* include/perf_sel_pkg.sv */
/*
 * constants for the event-select decoder: register map, field positions,
 * event codes and unit masks.
 * assumes a 4-bit byte-address register port with 32-bit data.
 */
package perf_sel_pkg;
	// --------------------------------------------------------------
	// register map
	// --------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int INC_W = 3;
	localparam logic [3:0] OFS_SELECT = 4'h0;
	localparam logic [3:0] OFS_COUNT = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam int SEL_CODE_LSB = 0;
	localparam int SEL_MASK_LSB = 8;
	localparam int SEL_EN_BIT = 16;
	localparam int STAT_LEGAL_BIT = 0;
	localparam int STAT_ACTIVE_BIT = 1;
	localparam int STAT_INC_LSB = 4;
	localparam logic [7:0] CODE_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [31:0] COUNT_RST = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [INC_W-1:0] INC_ZERO = 3'h0;
	localparam logic [INC_W-1:0] INC_ONE = 3'h1;

	// --------------------------------------------------------------
	// event codes
	// --------------------------------------------------------------
	localparam logic [7:0] EV_RESOURCE_STALL = 8'hA2;
	localparam logic [7:0] EV_PARTIAL_STALL = 8'hD2;
	localparam logic [7:0] EV_SEG_LOAD = 8'h06;
	localparam logic [7:0] EV_UNHALTED = 8'h79;
	localparam logic [7:0] EV_PI_EXEC = 8'hB0;
	localparam logic [7:0] EV_PI_SAT = 8'hB1;
	localparam logic [7:0] EV_PI_UOP = 8'hB2;
	localparam logic [7:0] EV_PI_CLASS = 8'hB3;
	localparam logic [7:0] EV_TRANSITION = 8'hCC;
	localparam logic [7:0] EV_STATE_EMPTY = 8'hCD;
	localparam logic [7:0] EV_PI_RETIRED = 8'hCE;
	localparam logic [7:0] EV_SEG_REN_STALL = 8'hD4;
	localparam logic [7:0] EV_SEG_RENAME = 8'hD5;
	localparam logic [7:0] EV_RET_SEG_REN = 8'hD6;

	// --------------------------------------------------------------
	// unit masks
	// --------------------------------------------------------------
	localparam logic [7:0] UM_NONE = 8'h00;
	localparam logic [7:0] UM_ONE = 8'h01;
	localparam logic [7:0] UM_ALL4 = 8'h0F;
	localparam logic [7:0] UM_CLASS_FIELD = 8'h3F;
	localparam int N_CLASS = 6;
	localparam int N_SEG = 4;
endpackage

/* tb/perf_sel_asserts.sv */
/* relations between the register port, event pins and counter.
 * assumes event pins are synchronous to ref_clk. */
`timescale 1ns/1ps
module perf_sel_asserts (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [perf_sel_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [perf_sel_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [perf_sel_pkg::DATA_W-1:0] reg_rdata,
	input wire logic rename_buf_stall,
	input wire logic mem_buf_stall,
	input wire logic other_resource_stall,
	input wire logic mispredict_recovery_stall,
	input wire logic store_drain_stall,
	input wire logic halted,
	input wire logic [perf_sel_pkg::N_CLASS-1:0] packed_int_class,
	input wire logic [perf_sel_pkg::N_SEG-1:0] segment_rename,
	input wire logic count_active,
	input wire logic [perf_sel_pkg::DATA_W-1:0] count_value
);
	import perf_sel_pkg::*;
	// ----------------------------------------
	// shadow select; a counter write beats any event
	// ----------------------------------------
	logic [16:0] sel_r;
	wire logic cnt_wr = reg_wr && reg_addr == OFS_COUNT;
	wire logic run = sel_r[SEL_EN_BIT] && !cnt_wr;
	wire logic [7:0] code = sel_r[7:0];
	wire logic [7:0] mask = sel_r[15:8];
	wire logic stall_any = rename_buf_stall | mem_buf_stall | other_resource_stall
		| mispredict_recovery_stall | store_drain_stall;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sel_r <= 17'h0;
		end else if (reg_wr && reg_addr == OFS_SELECT) begin
			sel_r <= reg_wdata[16:0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// relations
	// ----------------------------------------
	chk_rd_idle: assert property (!reg_rd |=> reg_rdata == ZERO_WORD)
		else $error("read data not cleared");
	chk_rd_count: assert property (reg_rd && reg_addr == OFS_COUNT
		|=> reg_rdata == $past(count_value)) else $error("count read wrong");
	chk_cnt_write: assert property (cnt_wr |=> count_value == $past(reg_wdata))
		else $error("counter write lost");
	chk_unhalted_step: assert property (run && code == EV_UNHALTED && mask == UM_NONE
		|=> count_value == $past(count_value) + 32'(!$past(halted))) else $error("unhalted");
	chk_stall_sum: assert property (run && code == EV_RESOURCE_STALL && mask == UM_NONE
		|=> count_value == $past(count_value) + 32'($past(stall_any))) else $error("stall");
	chk_class_sum: assert property (run && code == EV_PI_CLASS && mask != UM_NONE
		&& (mask & ~UM_CLASS_FIELD) == UM_NONE |=> count_value == $past(count_value)
		+ 32'($countones($past(packed_int_class & mask[5:0])))) else $error("class sum");
	chk_seg_all: assert property (run && code == EV_SEG_RENAME && mask == UM_ALL4
		|=> count_value == $past(count_value) + 32'($countones($past(segment_rename))))
		else $error("rename sum");
	chk_idle_hold: assert property ((!sel_r[SEL_EN_BIT] || code == EV_PI_UOP
		&& mask != UM_ALL4) && !cnt_wr |=> $stable(count_value)) else $error("idle count");
	chk_active_lag: assert property (reg_wr && reg_addr == OFS_SELECT
		&& reg_wdata[15:0] == 16'h0079 |-> ##2 count_active == $past(reg_wdata[SEL_EN_BIT], 2))
		else $error("active flag");
	cover property (cnt_wr);
	cover property (run && code == EV_PI_CLASS);
	cover property (reg_rd && reg_addr == OFS_COUNT);
endmodule
bind perf_event_select_decoder perf_sel_asserts perf_sel_asserts_i (.*);

/* tb/pipe_event_model.sv */
/* pipeline units: turn a command word into per-cycle event pins.
 * assumes the bench changes cmd just after a rising edge. */
`timescale 1ns/1ps
module pipe_event_model (
	input wire logic [33:0] cmd,
	output logic [33:0] ev
);
	// a store-move mark only ever rides on an executed packed instruction
	assign ev = {cmd[33:13], cmd[12] & cmd[11], cmd[11:0]};
endmodule

/* tb/tb_top.sv */
/* self-checking bench for the event-select decoder.
 * assumes the pipeline model drives every event pin. */
`timescale 1ns/1ps
module tb_top;
	import perf_sel_pkg::*;
	logic ref_clk, rst_n, reg_wr, reg_rd, count_active;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, count_value;
	logic rename_buf_stall, mem_buf_stall, other_resource_stall, bus_queue_full_stall;
	logic miss_limit_stall, mispredict_recovery_stall, store_drain_stall, partial_alias_stall;
	logic flag_partial_stall, segment_load, halted, packed_int_exec, packed_store_move;
	logic saturating_exec, packed_int_microop, packed_to_float, float_to_packed;
	logic packed_state_empty_instruction, packed_int_retired, retired_segment_rename;
	logic [N_CLASS-1:0] packed_int_class;
	logic [N_SEG-1:0] segment_rename_stall, segment_rename;
	logic [33:0] cmd, ev;
	int error_cnt, cmp_count;
	assign {segment_rename, segment_rename_stall, packed_int_class, retired_segment_rename,
		packed_int_retired, packed_state_empty_instruction, float_to_packed, packed_to_float,
		packed_int_microop, saturating_exec, packed_store_move, packed_int_exec, halted,
		segment_load, flag_partial_stall, partial_alias_stall, store_drain_stall,
		mispredict_recovery_stall, miss_limit_stall, bus_queue_full_stall,
		other_resource_stall, mem_buf_stall, rename_buf_stall} = ev;
	perf_event_select_decoder perf_event_select_decoder_i (.*);
	pipe_event_model pipe_event_model_i (.cmd(cmd), .ev(ev));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_rd <= 1'b0;
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		check(what, reg_rdata, exp);
		@(posedge ref_clk);
	endtask
	// count write lands while events may be live, so only the three driven cycles and the one idle cycle after them remain
	task automatic ev_run(input logic [31:0] sel, input logic [33:0] c, input logic [31:0] exp);
		wr(OFS_SELECT, sel);
		wr(OFS_COUNT, ZERO_WORD);
		reg_wr <= 1'b0;
		cmd <= c;
		repeat (3) @(posedge ref_clk);
		cmd <= 34'h0;
		@(posedge ref_clk);
		rd(OFS_COUNT, exp, "count");
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		rd(OFS_SELECT, ZERO_WORD, "select");
		rd(OFS_COUNT, COUNT_RST, "count");
		wr(OFS_STATUS, 32'hFFFF_FFFF);
		wr(4'hC, 32'hFFFF_FFFF);
		rd(OFS_STATUS, ZERO_WORD, "status");
		rd(4'hC, ZERO_WORD, "unmapped");
		wr(OFS_COUNT, 32'h1234_5678);
		rd(OFS_COUNT, 32'h1234_5678, "count rw");
		$display("test regs done");
	endtask
	task automatic t_events();
		ev_run(32'h0001_00A2, 34'h1, 32'h3);
		ev_run(32'h0001_00A2, 34'h18, 32'h0);
		ev_run(32'h0001_00A2, 34'hA, 32'h3);
		ev_run(32'h0001_00A2, 34'h40, 32'h3);
		ev_run(32'h0001_00A2, 34'h20, 32'h3);
		ev_run(32'h0001_00D2, 34'h100, 32'h3);
		ev_run(32'h0001_00D2, 34'h80, 32'h3);
		ev_run(32'h0001_0006, 34'h200, 32'h3);
		ev_run(32'h0001_0079, 34'h400, 32'h1);
		rd(OFS_STATUS, 32'h0000_0013, "status");
		ev_run(32'h0000_0079, 34'h0, 32'h0);
		ev_run(32'h0001_0079, 34'h0, 32'h4);
		ev_run(32'h0001_00B0, 34'h1800, 32'h0);
		ev_run(32'h0001_00B0, 34'h800, 32'h3);
		ev_run(32'h0001_00B1, 34'h2000, 32'h3);
		for (int i = 0; i < N_CLASS; i++) ev_run(32'h0001_00B3 | (32'h0000_0100 << i), 34'h3F00000, 32'h3);
		ev_run(32'h0001_3FB3, 34'h3F00000, 32'h12);
		ev_run(32'h0001_00CC, 34'h8000, 32'h3);
		ev_run(32'h0001_01CC, 34'h8000, 32'h0);
		ev_run(32'h0001_01CC, 34'h10000, 32'h3);
		ev_run(32'h0001_00CD, 34'h20000, 32'h3);
		ev_run(32'h0001_00CE, 34'h40000, 32'h3);
		ev_run(32'h0001_00CE, 34'h800, 32'h0);
		ev_run(32'h0001_00D6, 34'h80000, 32'h3);
		ev_run(32'h0001_0FD4, 34'h3C000000, 32'hC);
		ev_run(32'h0001_02D4, 34'h3C000000, 32'h3);
		ev_run(32'h0001_0FD5, 34'h3C0000000, 32'hC);
		ev_run(32'h0001_08D5, 34'h3C0000000, 32'h3);
		ev_run(32'h0001_0FB2, 34'h4000, 32'h3);
		ev_run(32'h0001_00B2, 34'h4000, 32'h0);
		$display("test events done");
	endtask
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		#3000000;
		error_cnt++;
		summarize();
	end
	initial begin
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, cmd} = '0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs();
		t_events();
		summarize();
	end
endmodule
